// ==== rtl/rcss_pkg.sv ====
package rcss_pkg;
    localparam int NUM_CH = 10;
    localparam int CH_W = 4;
    localparam int CNT_W = 10;
    localparam logic [CH_W-1:0] CH_NONE = 4'h0;
    localparam logic [CH_W-1:0] CH_FIRST = 4'h1;
    localparam logic [CH_W-1:0] CH_LAST = 4'ha;
    localparam logic [CH_W-1:0] PAIR_OFFSET = 4'h5;
    localparam logic [CH_W-1:0] PAIR_LOW_MIN = 4'h2;
    localparam logic [CH_W-1:0] PAIR_LOW_MAX = 4'h5;
    localparam int CLK_HZ = 50_000_000;
    localparam int SETTLE_US = 100;
    localparam int SETTLE_CYC = SETTLE_US * (CLK_HZ / 1_000_000);
    localparam int DWELL_US = 200;
    localparam int DWELL_CYC = DWELL_US * (CLK_HZ / 1_000_000);
    localparam int REPEAT_MS = 250;
    localparam int REPEAT_CYC = REPEAT_MS * (CLK_HZ / 1_000);
    typedef enum logic [1:0] {
        RCSS_MODE_MANUAL,
        RCSS_MODE_STEP,
        RCSS_MODE_SCAN
    } rcss_mode_t;
    typedef enum logic [2:0] {
        RCSS_IDLE,
        RCSS_OPENING,
        RCSS_SETTLE,
        RCSS_CLOSING,
        RCSS_DWELL
    } rcss_state_t;
endpackage

// ==== rtl/rcss_tick.sv ====
`timescale 1ns/1ps
// Down-counter that fires one pulse when a loaded interval expires
module rcss_tick #(
    parameter int WIDTH = 24
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic load_i,
    input wire logic [WIDTH-1:0] value_i,
    output logic done_o
);
    logic [WIDTH-1:0] cnt_r;
    logic run_r;

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cnt_r <= '0;
            run_r <= 1'b0;
        end else if (load_i) begin
            cnt_r <= value_i;
            run_r <= 1'b1;
        end else if (run_r) begin
            if (cnt_r <= WIDTH'(1)) begin
                run_r <= 1'b0;
            end
            cnt_r <= cnt_r - WIDTH'(1);
        end
    end

    assign done_o = run_r && (cnt_r <= WIDTH'(1)) && !load_i;
endmodule // rcss_tick

// ==== rtl/rcss_sequencer.sv ====
`timescale 1ns/1ps
// Summary of operation
// - Close directly selected channel one to ten
// - Open old channel, settle, then close new
// - Four-wire mode closes channel two to five and partner
// - Partner pairs are low channel plus five
// - Open command opens everything immediately
// - Step-up and step-down move one channel
// - Held step request keeps advancing channels
// - Per-channel indicator shows closed channel
// - Step mode triggers after each closure
// - Step mode ends at reading count closures
// - Scan mode triggers once per pass
// - Scan passes cover at least reading count
// - Scan ends after last channel of last pass
// - Halt leaves step or scan mode
// - List length is last minus first plus one
// - Stepping wraps from last list channel to first
module rcss_sequencer #(
    parameter int SETTLE_CYCLES = rcss_pkg::SETTLE_CYC,
    parameter int DWELL_CYCLES = rcss_pkg::DWELL_CYC,
    parameter int REPEAT_CYCLES = rcss_pkg::REPEAT_CYC
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic [rcss_pkg::CH_W-1:0] sel_channel_i,
    input wire logic close_i,
    input wire logic open_all_i,
    input wire logic step_up_i,
    input wire logic step_down_i,
    input wire logic four_wire_i,
    input wire logic [rcss_pkg::CH_W-1:0] first_channel_i,
    input wire logic [rcss_pkg::CH_W-1:0] last_channel_i,
    input wire logic [rcss_pkg::CNT_W-1:0] reading_count_i,
    input wire logic start_step_i,
    input wire logic start_scan_i,
    input wire logic halt_i,
    output logic [rcss_pkg::NUM_CH-1:0] relay_o,
    output logic [rcss_pkg::NUM_CH-1:0] indicator_o,
    output logic [rcss_pkg::CH_W-1:0] closed_channel_o,
    output logic trigger_o,
    output logic busy_o,
    output logic [1:0] mode_o
);
    import rcss_pkg::*;

    localparam int TW = 24;

    rcss_state_t state_r;
    rcss_mode_t mode_r;
    logic [CH_W-1:0] cur_r;
    logic [CH_W-1:0] target_r;
    logic [CNT_W-1:0] done_cnt_r;
    logic [CNT_W-1:0] pass_pos_r;
    logic [TW-1:0] repeat_cnt_r;
    logic tmr_load;
    logic [TW-1:0] tmr_val;
    logic tmr_done;
    logic held;
    logic repeat_fire;
    logic [CNT_W-1:0] list_len;
    logic [CH_W-1:0] up_ch;
    logic [CH_W-1:0] dn_ch;
    logic [CH_W-1:0] list_next;
    logic last_closure;
    logic pass_end;
    rcss_state_t state_nxt;
    logic start_any;
    logic close_ok;
    logic dwell_end;
    logic abort;
    logic [NUM_CH-1:0] close_mask;

    ////////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic logic [NUM_CH-1:0] ch_mask(input logic [CH_W-1:0] ch,
                                                  input logic fw);
        logic [NUM_CH-1:0] m;
        m = '0;
        if (ch >= CH_FIRST && ch <= CH_LAST) begin
            m[ch - CH_FIRST] = 1'b1;
            if (fw && ch >= PAIR_LOW_MIN && ch <= PAIR_LOW_MAX) begin
                m[ch + PAIR_OFFSET - CH_FIRST] = 1'b1;
            end
        end
        return m;
    endfunction

    assign list_len = CNT_W'(last_channel_i - first_channel_i) + CNT_W'(1);
    assign up_ch = (cur_r >= CH_LAST || cur_r == CH_NONE) ? CH_FIRST
                                                           : cur_r + CH_FIRST;
    assign dn_ch = (cur_r <= CH_FIRST) ? CH_LAST : cur_r - CH_FIRST;
    assign list_next = (cur_r >= last_channel_i) ? first_channel_i
                                                  : cur_r + CH_FIRST;
    assign pass_end = (pass_pos_r + CNT_W'(1)) >= list_len;
    // Step ends at the count; scan only at a pass boundary at or past the count
    assign last_closure = (mode_r == RCSS_MODE_STEP)
                        ? (done_cnt_r + CNT_W'(1)) >= reading_count_i
                        : pass_end && (done_cnt_r + CNT_W'(1)) >= reading_count_i;

    ////////////////////////////////////////////////////////////////////////
    // Key repeat: a held step request fires again every repeat interval

    assign held = (step_up_i ^ step_down_i) && mode_r == RCSS_MODE_MANUAL;
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            repeat_cnt_r <= '0;
        end else if (!held || repeat_fire) begin
            repeat_cnt_r <= '0;
        end else begin
            repeat_cnt_r <= repeat_cnt_r + TW'(1);
        end
    end
    // First press acts at once, then at the repeat rate
    assign repeat_fire = held && state_r == RCSS_IDLE
                      && (repeat_cnt_r == '0 || repeat_cnt_r >= TW'(REPEAT_CYCLES));

    ////////////////////////////////////////////////////////////////////////
    // Interval timer shared by settle and dwell

    rcss_tick #(
        .WIDTH(TW)
    ) u_tick (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .load_i(tmr_load),
        .value_i(tmr_val),
        .done_o(tmr_done)
    );

    always_comb begin
        tmr_load = 1'b0;
        tmr_val = TW'(SETTLE_CYCLES);
        if (state_r == RCSS_OPENING) begin
            tmr_load = 1'b1;
        end else if (state_r == RCSS_CLOSING && mode_r != RCSS_MODE_MANUAL) begin
            tmr_load = 1'b1;
            tmr_val = TW'(DWELL_CYCLES);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequence control

    assign start_any = start_step_i || start_scan_i;
    assign close_ok = mode_r == RCSS_MODE_MANUAL && close_i
                   && sel_channel_i >= CH_FIRST && sel_channel_i <= CH_LAST;
    assign dwell_end = state_r == RCSS_DWELL && tmr_done;
    assign abort = halt_i || open_all_i;

    // Halt and open-all win over any request taken in the same cycle
    always_comb begin
        state_nxt = state_r;
        if (abort) begin
            state_nxt = RCSS_IDLE;
        end else begin
            unique case (state_r)
                RCSS_IDLE: begin
                    if (start_any) begin
                        state_nxt = RCSS_OPENING;
                    end else if (close_ok) begin
                        // Same channel again needs no break and settle
                        state_nxt = (sel_channel_i == cur_r) ? RCSS_CLOSING
                                                             : RCSS_OPENING;
                    end else if (repeat_fire) begin
                        state_nxt = RCSS_OPENING;
                    end
                end
                RCSS_OPENING: begin
                    state_nxt = RCSS_SETTLE;
                end
                RCSS_SETTLE: begin
                    if (tmr_done) begin
                        state_nxt = RCSS_CLOSING;
                    end
                end
                RCSS_CLOSING: begin
                    state_nxt = (mode_r == RCSS_MODE_MANUAL) ? RCSS_IDLE : RCSS_DWELL;
                end
                RCSS_DWELL: begin
                    if (tmr_done) begin
                        state_nxt = last_closure ? RCSS_IDLE : RCSS_OPENING;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_r <= RCSS_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            mode_r <= RCSS_MODE_MANUAL;
        end else if (abort) begin
            mode_r <= RCSS_MODE_MANUAL;
        end else if (state_r == RCSS_IDLE && start_any) begin
            // Step wins when both starts arrive together
            mode_r <= start_step_i ? RCSS_MODE_STEP : RCSS_MODE_SCAN;
        end else if (dwell_end && last_closure) begin
            mode_r <= RCSS_MODE_MANUAL;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            target_r <= CH_NONE;
        end else if (!abort) begin
            if (state_r == RCSS_IDLE && start_any) begin
                target_r <= first_channel_i;
            end else if (state_r == RCSS_IDLE && close_ok) begin
                target_r <= sel_channel_i;
            end else if (repeat_fire) begin
                target_r <= step_up_i ? up_ch : dn_ch;
            end else if (dwell_end && !last_closure) begin
                target_r <= list_next;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            done_cnt_r <= '0;
            pass_pos_r <= '0;
        end else if (!abort) begin
            if (state_r == RCSS_IDLE && start_any) begin
                done_cnt_r <= '0;
                pass_pos_r <= '0;
            end else if (dwell_end) begin
                done_cnt_r <= done_cnt_r + CNT_W'(1);
                pass_pos_r <= pass_end ? '0 : pass_pos_r + CNT_W'(1);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Relay drive and indicators

    assign close_mask = ch_mask(target_r, four_wire_i);

    // Open-all beats halt; a halt alone leaves the relays as they stand
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            relay_o <= '0;
        end else if (open_all_i) begin
            relay_o <= '0;
        end else if (!halt_i) begin
            if (state_r == RCSS_OPENING) begin
                relay_o <= '0;
            end else if (state_r == RCSS_CLOSING) begin
                // The pair one/six is never requested by the controller
                relay_o <= close_mask;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            indicator_o <= '0;
        end else if (open_all_i) begin
            indicator_o <= '0;
        end else if (!halt_i) begin
            if (state_r == RCSS_OPENING) begin
                indicator_o <= '0;
            end else if (state_r == RCSS_CLOSING) begin
                indicator_o <= close_mask;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cur_r <= CH_NONE;
        end else if (open_all_i) begin
            cur_r <= CH_NONE;
        end else if (!halt_i) begin
            if (state_r == RCSS_OPENING) begin
                cur_r <= CH_NONE;
            end else if (state_r == RCSS_CLOSING) begin
                cur_r <= target_r;
            end
        end
    end

    assign closed_channel_o = cur_r;

    ////////////////////////////////////////////////////////////////////////
    // Output trigger

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            trigger_o <= 1'b0;
        end else if (abort) begin
            trigger_o <= 1'b0;
        end else if (dwell_end) begin
            // Scan triggers only at the end of a pass
            trigger_o <= (mode_r == RCSS_MODE_STEP)
                      || (mode_r == RCSS_MODE_SCAN && pass_end);
        end else begin
            trigger_o <= 1'b0;
        end
    end

    assign busy_o = state_r != RCSS_IDLE;
    assign mode_o = mode_r;
endmodule // rcss_sequencer

// ==== test/rcss_sequencer_asserts.sv ====
`timescale 1ns/1ps
module rcss_sequencer_chk (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic open_all_i,
    input wire logic halt_i,
    input wire logic start_step_i,
    input wire logic [9:0] relay_o,
    input wire logic [9:0] indicator_o,
    input wire logic trigger_o,
    input wire logic busy_o,
    input wire logic [1:0] mode_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    property p_open; open_all_i |=> relay_o == 10'h0; endproperty
    a_open: assert property (p_open) else $error("relays stay closed");
    property p_ind; indicator_o == relay_o; endproperty
    a_ind: assert property (p_ind) else $error("indicator differs");
    property p_pair; $countones(relay_o) <= 2 && !(relay_o[0] && relay_o[5]); endproperty
    a_pair: assert property (p_pair) else $error("bad relay pair");
    property p_swap; (relay_o != 10'h0 && $past(relay_o) != 10'h0) |-> relay_o == $past(relay_o);
    endproperty
    a_swap: assert property (p_swap) else $error("break before make lost");
    property p_settle; ($fell(relay_o != 10'h0) && busy_o) |-> (relay_o == 10'h0)[*3];
    endproperty
    a_settle: assert property (p_settle) else $error("settle too short");
    property p_pulse; trigger_o |=> !trigger_o; endproperty
    a_pulse: assert property (p_pulse) else $error("trigger too long");
    property p_trg_mode; trigger_o |-> $past(mode_o) != 2'h0; endproperty
    a_trg_mode: assert property (p_trg_mode) else $error("manual trigger");
    property p_halt; halt_i |=> mode_o == 2'h0; endproperty
    a_halt: assert property (p_halt) else $error("halt ignored");
    property p_go;
        (start_step_i && !busy_o && mode_o == 2'h0 && !halt_i && !open_all_i) |=> mode_o == 2'h1;
    endproperty
    a_go: assert property (p_go) else $error("step not started");
    c_trig: cover property (trigger_o);
    c_scan: cover property (mode_o == 2'h2);
    c_pair: cover property (relay_o[1] && relay_o[6]);
endmodule // rcss_sequencer_chk
bind rcss_sequencer rcss_sequencer_chk u_chk (.clk_i(clk_i), .rstn_i(rstn_i),
    .open_all_i(open_all_i), .halt_i(halt_i), .start_step_i(start_step_i), .relay_o(relay_o),
    .indicator_o(indicator_o), .trigger_o(trigger_o), .busy_o(busy_o), .mode_o(mode_o));

// ==== test/rcss_relay_bank.sv ====
`timescale 1ns/1ps
// Contacts follow their coils one clock late
module rcss_relay_bank (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic [9:0] coil_i,
    output logic [9:0] contact_o
);
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            contact_o <= 10'h0;
        end else begin
            contact_o <= coil_i;
        end
    end
endmodule // rcss_relay_bank

// ==== test/relay_channel_scan_sequencer_tb.sv ====
`timescale 1ns/1ps
module relay_channel_scan_sequencer_tb;
    import rcss_pkg::*;
    logic clk_i = 0, rstn_i = 0, close_i = 0, open_all_i = 0, step_up_i = 0, step_down_i = 0;
    logic four_wire_i = 0, start_step_i = 0, start_scan_i = 0, halt_i = 0;
    logic [3:0] sel_channel_i = 4'h1, first_channel_i = 4'h1, last_channel_i = 4'h1, c;
    logic [9:0] reading_count_i = 10'h1, relay_o, indicator_o, contact, prev = 10'h0;
    logic [3:0] closed_channel_o;
    logic trigger_o, busy_o;
    logic [1:0] mode_o;
    logic [9:0] exp_q[$];
    logic [31:0] rnd = 32'h33;
    int mismatches = 0, checked = 0, trg = 0, i;
    rcss_sequencer #(.SETTLE_CYCLES(4), .DWELL_CYCLES(4), .REPEAT_CYCLES(20)) DUT (
        .clk_i(clk_i), .rstn_i(rstn_i), .sel_channel_i(sel_channel_i), .close_i(close_i),
        .open_all_i(open_all_i), .step_up_i(step_up_i), .step_down_i(step_down_i),
        .four_wire_i(four_wire_i), .first_channel_i(first_channel_i),
        .last_channel_i(last_channel_i), .reading_count_i(reading_count_i),
        .start_step_i(start_step_i), .start_scan_i(start_scan_i), .halt_i(halt_i),
        .relay_o(relay_o), .indicator_o(indicator_o), .closed_channel_o(closed_channel_o),
        .trigger_o(trigger_o), .busy_o(busy_o), .mode_o(mode_o));
    rcss_relay_bank u_bank (.clk_i(clk_i), .rstn_i(rstn_i), .coil_i(relay_o), .contact_o(contact));
    initial begin
        forever #10 clk_i = ~clk_i;
    end
    ////////////////////////////////////////////////////////////////
    function automatic logic [9:0] m(input logic [3:0] ch);
        m = 10'h1 << (ch - 4'h1);
        if (four_wire_i && ch >= 4'h2 && ch <= 4'h5) m |= 10'h1 << (ch + 4'h4);
    endfunction
    task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic wt(input logic mode);
        i = 0;
        do begin cyc(1); i++; end while ((mode ? mode_o !== 2'h0 : busy_o !== 1'b0) && i < 3000);
        // One more edge so the monitor has counted a trigger sent as the last dwell ends
        cyc(1);
        chk("done", {mode_o, busy_o}, 16'h0);
    endtask
    task automatic pulse(ref logic s, input logic mode);
        s = 1;
        cyc(1);
        s = 0;
        wt(mode);
    endtask
    task automatic close(input logic [3:0] ch);
        exp_q.push_back(m(ch));
        sel_channel_i = ch;
        pulse(close_i, 0);
    endtask
    task automatic auto(ref logic s, input logic [3:0] f, l, input logic [9:0] n);
        pulse(open_all_i, 0);
        first_channel_i = f;
        last_channel_i = l;
        reading_count_i = n;
        trg = 0;
        s = 1;
        cyc(1);
        s = 0;
    endtask
    task automatic end_sim;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    // Every new closure must match the oldest note
    always @(posedge clk_i) begin
        if (trigger_o === 1'b1) trg++;
        if (relay_o !== prev && relay_o !== 10'h0) begin
            chk("queued", exp_q.size() > 0, 1'b1);
            chk("relay", relay_o, exp_q.pop_front());
            chk("indicator", indicator_o, relay_o);
        end
        prev = relay_o;
    end
    initial begin
        #200_000;
        mismatches++;
        end_sim();
    end
    initial begin
        cyc(4);
        rstn_i = 1;
        cyc(1);
        for (int k = 0; k < 8; k++) begin
            rnd ^= rnd << 13;
            rnd ^= rnd >> 17;
            rnd ^= rnd << 5;
            c = 4'(rnd % 32'd10) + 4'h1;
            if (c === closed_channel_o) c = (c == 4'ha) ? 4'h1 : c + 4'h1;
            close(c);
        end
        $display("test manual done");
        pulse(open_all_i, 0);
        chk("open", relay_o, 16'h0);
        four_wire_i = 1;
        for (int k = 2; k <= 5; k++) close(4'(k));
        close(4'h7);
        pulse(open_all_i, 0);
        chk("contacts", contact, 16'h0);
        four_wire_i = 0;
        $display("test four wire done");
        close(4'ha);
        exp_q.push_back(m(4'h1));
        pulse(step_up_i, 0);
        exp_q.push_back(m(4'ha));
        pulse(step_down_i, 0);
        exp_q.push_back(m(4'h9));
        pulse(step_down_i, 0);
        exp_q.push_back(m(4'ha));
        for (int k = 1; k <= 3; k++) exp_q.push_back(m(4'(k)));
        step_up_i = 1;
        i = 0;
        while (closed_channel_o !== 4'h3 && i < 500) begin cyc(1); i++; end
        step_up_i = 0;
        wt(0);
        chk("held", closed_channel_o, 16'h3);
        $display("test keys done");
        for (int k = 0; k < 4; k++) exp_q.push_back(m(4'(3 + k % 3)));
        auto(start_step_i, 4'h3, 4'h5, 10'h4);
        wt(1);
        chk("step triggers", trg, 16'h4);
        chk("step left", exp_q.size(), 16'h0);
        $display("test step done");
        for (int k = 0; k < 6; k++) exp_q.push_back(m(4'(2 + k % 3)));
        auto(start_scan_i, 4'h2, 4'h4, 10'h4);
        wt(1);
        chk("scan triggers", trg, 16'h2);
        chk("scan left", exp_q.size(), 16'h0);
        $display("test scan done");
        // One-channel list recloses every ten cycles: six closures before the halt
        for (int k = 0; k < 6; k++) exp_q.push_back(m(4'h7));
        auto(start_step_i, 4'h7, 4'h7, 10'h3e8);
        cyc(60);
        pulse(halt_i, 1);
        chk("halt relay", relay_o, m(4'h7));
        chk("halt left", exp_q.size(), 16'h0);
        $display("test halt done");
        end_sim();
    end
endmodule // relay_channel_scan_sequencer_tb
